// [verilog/adcc_top.sv]
/*
 * Conversion control of an eight-input successive-approximation
 * converter, with an AHB-Lite register slave and a level interrupt.
 * Assumes one slave on the bus (hready is our own hreadyout), an
 * external comparator that reports input above the trial code, and
 * a trigger pin already synchronous to hclk.
 */
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps

// Functional notes
// R01: Eight inputs share one conversion engine
// R02: Each outcome lands in the result register
// R03: Successive approximation, about 7.5 us each
// R04: Trigger pin edge starts hardware-start conversion
// R05: Software start bit in mode register starts
// R06: Scan mode steps through channels in sequence
// R07: Select mode repeats one chosen channel
// R08: Mode register holds mode and run/stop
// R09: Each result transfer raises done interrupt
// R10: Trigger pin is edge sensitive, one start
// R11: New result overwrites; scan wraps to first
module adcc_top (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output      logic              hreadyout,
    output      logic              hresp,
    output      logic [31:0]       hrdata,
    input  wire logic              external_trigger_input,
    input  wire logic              compare_above,
    output      adcc_pkg::adcc_afe_t afe,
    output      logic              conversion_done_irq
);
    import adcc_pkg::*;

    // Whole state of the block
    typedef struct packed {
        adcc_state_t      st;              // Sequencer state
        logic [CNT_W-1:0] cnt;             // Phase countdown
        logic [2:0]       bitn;            // Bit under trial
        logic [RES_W-1:0] code;            // Trial / decided code
        logic [CH_W-1:0]  chan;            // Channel being converted
        logic             samp;            // Sample phase output
        logic             active;          // Started and not halted
        logic             trig_q;          // Trigger pin, last cycle
        logic             done_ev;         // Result just transferred
        adcc_mode_t       mode;            // Mode register
        logic [RES_W-1:0] result;          // Conversion result
        logic [STAT_W-1:0] stat;           // Sticky events
        logic [STAT_W-1:0] mask;           // Interrupt enables
        logic             irq;             // Interrupt output
        logic             wr_pend;         // Write data phase
        logic             rd_pend;         // Read wait state
        logic [7:0]       addr;            // Latched offset
        logic [31:0]      rdata;           // Read data
        logic             rdy;             // hreadyout
        logic             resp;            // Always OKAY
    } adcc_core_t;

    adcc_core_t        s;                  // Registered state
    adcc_core_t        next_s;             // Next state
    logic              hw_edge;            // Rising edge on trigger pin
    logic              hw_start;           // Edge that may start
    logic              sw_start;           // Software start write
    logic              halt;               // Run bit written zero
    logic [STAT_W-1:0] stat_set;           // Events this cycle
    logic [STAT_W-1:0] w1c;                // Bits software clears
    logic [31:0]       rword;              // Read word under build

    // Next-state logic for bus, sequencer and events
    always_comb begin
        next_s   = s;
        stat_set = '0;
        w1c      = '0;
        rword    = '0;
        next_s.trig_q  = external_trigger_input;
        next_s.done_ev = 1'b0;
        next_s.rdy     = 1'b1;
        next_s.wr_pend = 1'b0;
        next_s.rd_pend = 1'b0;
        next_s.resp    = 1'b0;

        // Only rising edges count, a held level starts nothing
        hw_edge  = external_trigger_input && !s.trig_q;   // R10
        hw_start = hw_edge && s.mode.run && s.mode.hw_en; // R04
        sw_start = s.wr_pend && (s.addr == ADDR_MODE)
                   && hwdata[MODE_START_BIT]
                   && hwdata[MODE_RUN_BIT];               // R05
        halt     = s.wr_pend && (s.addr == ADDR_MODE)
                   && !hwdata[MODE_RUN_BIT];              // R08

        // Address phase: reads get one wait state so that they
        // see any write finishing in the same cycle
        if (hsel && htrans[1] && hready) begin
            next_s.addr    = haddr[7:0];
            next_s.wr_pend = hwrite;
            next_s.rd_pend = !hwrite;
            next_s.rdy     = hwrite;
        end

        // Read data, unmapped offsets read zero
        if (s.rd_pend) begin
            if (s.addr == ADDR_MODE) begin
                rword[MODE_W-1:0] = s.mode;
            end else if (s.addr == ADDR_RESULT) begin
                rword[RES_W-1:0] = s.result;              // R02
            end else if (s.addr == ADDR_STATUS) begin
                rword[STAT_W-1:0]             = s.stat;
                rword[STAT_BUSY_BIT]          = s.st != ST_IDLE;
                rword[STAT_CH_LSB +: CH_W]    = s.chan;
            end else if (s.addr == ADDR_MASK) begin
                rword[STAT_W-1:0] = s.mask;
            end
            next_s.rdata = rword;
        end

        // Write data phase, unmapped writes are dropped
        if (s.wr_pend) begin
            if (s.addr == ADDR_MODE) begin
                next_s.mode       = hwdata[MODE_W-1:0];   // R08
                next_s.mode.start = 1'b0;
            end else if (s.addr == ADDR_STATUS) begin
                w1c = hwdata[STAT_W-1:0];
            end else if (s.addr == ADDR_MASK) begin
                next_s.mask = hwdata[STAT_W-1:0];
            end
        end

        // Sequencer
        case (s.st)
            ST_IDLE: begin
                // Starts while busy are ignored
                if (sw_start || hw_start) begin           // R04 R05
                    next_s.active = 1'b1;
                    next_s.st     = ST_SAMPLE;
                    next_s.samp   = 1'b1;
                    next_s.cnt    = CNT_W'(SAMPLE_CYC - 1);
                    // Scan begins at the first input
                    next_s.chan   = next_s.mode.scan ? '0
                                  : next_s.mode.chan;     // R01
                end
            end
            ST_SAMPLE: begin
                if (s.cnt == '0) begin
                    next_s.st   = ST_BITS;
                    next_s.samp = 1'b0;
                    next_s.cnt  = CNT_W'(BIT_CYC - 1);
                    next_s.bitn = 3'(RES_W - 1);
                    next_s.code = 8'h80;                  // R03
                end else begin
                    next_s.cnt = s.cnt - 1'b1;
                end
            end
            ST_BITS: begin
                if (s.cnt == '0) begin
                    // Keep the trial bit only if input is above
                    next_s.code[s.bitn] = compare_above;  // R03
                    if (s.bitn == 3'h0) begin
                        // Older result is simply overwritten
                        next_s.result  = next_s.code;     // R02 R11
                        next_s.done_ev = 1'b1;
                        stat_set[STAT_DONE_BIT] = 1'b1;   // R09
                        if (next_s.mode.scan) begin
                            // Past the last channel wraps to first
                            next_s.chan =
                                (s.chan >= next_s.mode.chan) ? '0
                                : s.chan + 3'h1;          // R06 R11
                        end else begin
                            next_s.chan = next_s.mode.chan; // R07
                        end
                        // Keep converting until stopped
                        next_s.st   = ST_SAMPLE;
                        next_s.samp = 1'b1;
                        next_s.cnt  = CNT_W'(SAMPLE_CYC - 1);
                    end else begin
                        next_s.bitn = s.bitn - 3'h1;
                        next_s.code[s.bitn - 3'h1] = 1'b1;
                        next_s.cnt  = CNT_W'(BIT_CYC - 1);
                    end
                end else begin
                    next_s.cnt = s.cnt - 1'b1;
                end
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase

        // Stop aborts a conversion in flight, no result
        if (halt) begin                                   // R08
            next_s.active = 1'b0;
            next_s.st     = ST_IDLE;
            next_s.samp   = 1'b0;
            // A result falling due in the same cycle is dropped too
            next_s.result  = s.result;
            next_s.done_ev = 1'b0;
            stat_set[STAT_DONE_BIT] = 1'b0;
        end

        // Every detected edge is logged, even if ignored
        if (hw_edge) begin
            stat_set[STAT_TRIG_BIT] = 1'b1;
        end

        // Set wins over a clear in the same cycle
        next_s.stat = (s.stat & ~w1c) | stat_set;         // R09
        next_s.irq  = |(next_s.stat & next_s.mask);
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s           <= '0;
            s.mode      <= MODE_RESET;
            s.mask      <= MASK_RESET;
            s.rdy       <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from state flops
    assign hreadyout           = s.rdy;
    assign hresp               = s.resp;
    assign hrdata              = s.rdata;
    assign conversion_done_irq = s.irq;
    // One driver for the whole carrier
    assign afe                 = '{sample: s.samp, chan: s.chan, dac: s.code};

    // Checking: busy cycles of the conversion just finished
    logic [CNT_W-1:0] age;                 // Assertion helper

    // Counts cycles since the current conversion began
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            age <= '0;
        end else if (s.st == ST_IDLE) begin
            age <= '0;
        end else if (s.done_ev) begin
            age <= 11'h001;
        end else begin
            age <= age + 11'h001;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_r01_chan_held;
        s.st == ST_BITS |-> $stable(s.chan);
    endproperty
    a_r01_chan_held: assert property (p_r01_chan_held) // R01
        else $error("channel moved during conversion");

    property p_r02_result_source;
        $changed(s.result) |-> s.done_ev;
    endproperty
    a_r02_result_source: assert property (p_r02_result_source) // R02
        else $error("result changed without a conversion");

    property p_r03_conv_time;
        s.done_ev |-> age == CONV_CYC;
    endproperty
    a_r03_conv_time: assert property (p_r03_conv_time) // R03
        else $error("conversion length wrong");

    property p_r03_first_trial;
        s.st == ST_SAMPLE && s.cnt == '0 && !halt
            |=> s.st == ST_BITS && afe.dac == 8'h80;
    endproperty
    a_r03_first_trial: assert property (p_r03_first_trial) // R03
        else $error("search did not begin at mid-scale");

    property p_r04_hw_start;
        hw_start && s.st == ST_IDLE && !halt
            |=> s.st == ST_SAMPLE && s.samp && s.active;
    endproperty
    a_r04_hw_start: assert property (p_r04_hw_start) // R04
        else $error("trigger edge did not start");

    property p_r05_sw_start;
        sw_start && s.st == ST_IDLE
            |=> s.active && s.st == ST_SAMPLE ##1 s.samp;
    endproperty
    a_r05_sw_start: assert property (p_r05_sw_start) // R05
        else $error("software start ignored");

    property p_r06_scan_step;
        s.done_ev && s.mode.scan && $stable(s.mode)
            && $past(s.chan) < s.mode.chan
            |-> s.chan == 3'($past(s.chan) + 3'h1);
    endproperty
    a_r06_scan_step: assert property (p_r06_scan_step) // R06
        else $error("scan did not step to next channel");

    property p_r07_select_hold;
        s.done_ev && !s.mode.scan |-> s.chan == s.mode.chan;
    endproperty
    a_r07_select_hold: assert property (p_r07_select_hold) // R07
        else $error("select mode left its channel");

    property p_r08_halt;
        halt |=> !s.active && s.st == ST_IDLE && !afe.sample;
    endproperty
    a_r08_halt: assert property (p_r08_halt) // R08
        else $error("stop did not halt the converter");

    property p_r08_idle_quiet;
        s.st == ST_IDLE |-> !afe.sample && !s.done_ev;
    endproperty
    a_r08_idle_quiet: assert property (p_r08_idle_quiet) // R08
        else $error("idle converter sampling or finishing");

    property p_r09_done_flag;
        s.done_ev |-> s.stat[STAT_DONE_BIT]
            && (conversion_done_irq || !s.mask[STAT_DONE_BIT]);
    endproperty
    a_r09_done_flag: assert property (p_r09_done_flag) // R09
        else $error("done event not flagged");

    property p_r10_edge_only;
        hw_start |-> external_trigger_input
            && !$past(external_trigger_input);
    endproperty
    a_r10_edge_only: assert property (p_r10_edge_only) // R10
        else $error("start without a rising edge");

    property p_r10_edge_logged;
        hw_edge |=> s.stat[STAT_TRIG_BIT];
    endproperty
    a_r10_edge_logged: assert property (p_r10_edge_logged) // R10
        else $error("trigger edge not logged");

    property p_r11_scan_wrap;
        s.done_ev && s.mode.scan && $stable(s.mode)
            && $past(s.chan) == s.mode.chan |-> s.chan == 3'h0;
    endproperty
    a_r11_scan_wrap: assert property (p_r11_scan_wrap) // R11
        else $error("scan did not wrap to first channel");

endmodule : adcc_top

// [verilog/adcc_pkg.sv]
/*
 * Shared constants and types of the converter control block:
 * register offsets, field positions, reset values, timing counts,
 * the sequencer states and the analog front-end carrier.
 * Assumes a 200 MHz bus clock and an 8-bit, 8-input converter.
 */
package adcc_pkg;

    // Converter geometry
    localparam int NUM_CH = 8;             // Multiplexed inputs
    localparam int CH_W   = 3;             // Channel index width
    localparam int RES_W  = 8;             // Result width

    // Timing: conversion time as printed, in nanoseconds
    localparam int CONV_TIME_NS = 7500;    // About 7.5 us
    localparam int CLK_MHZ      = 200;     // Bus clock rate
    // Least time, so round up to whole cycles
    localparam int CONV_CYC   = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int BIT_CYC    = CONV_CYC / (RES_W + 1);
    localparam int SAMPLE_CYC = CONV_CYC - RES_W * BIT_CYC;
    localparam int CNT_W      = 11;        // Holds the longest phase

    // Register byte offsets
    localparam logic [7:0] ADDR_MODE   = 8'h00;
    localparam logic [7:0] ADDR_RESULT = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_MASK   = 8'h0C;

    // Mode register fields
    localparam int MODE_RUN_BIT   = 0;     // Run / stop
    localparam int MODE_SCAN_BIT  = 1;     // 1 scan, 0 select
    localparam int MODE_START_BIT = 2;     // Software start, self-clearing
    localparam int MODE_HWEN_BIT  = 3;     // Trigger pin start enable
    localparam int MODE_CH_LSB    = 4;     // Channel / last scan channel
    localparam int MODE_W         = 7;
    localparam logic [MODE_W-1:0] MODE_RESET = 7'h00;

    // Status and mask fields
    localparam int STAT_W        = 2;
    localparam int STAT_DONE_BIT = 0;      // Result transferred
    localparam int STAT_TRIG_BIT = 1;      // Trigger edge seen
    localparam int STAT_BUSY_BIT = 8;      // Read-only busy
    localparam int STAT_CH_LSB   = 16;     // Read-only current channel
    localparam logic [STAT_W-1:0] MASK_RESET = 2'h0;

    // Mode register layout, msb first
    typedef struct packed {
        logic [CH_W-1:0] chan;             // Channel field
        logic            hw_en;            // Trigger pin enable
        logic            start;            // Always reads zero
        logic            scan;             // Scan when set
        logic            run;              // Converter running
    } adcc_mode_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_BITS
    } adcc_state_t;

    // Analog front-end controls
    typedef struct packed {
        logic             sample;          // Sample-and-hold closed
        logic [CH_W-1:0]  chan;            // Multiplexer select
        logic [RES_W-1:0] dac;             // Trial code to comparator
    } adcc_afe_t;

endpackage : adcc_pkg

// [testbench/adcc_analog_model.sv]
/*
 * Behavioural analog front end: eight fixed input levels, the input
 * multiplexer and the comparator that the converter steers.
 * Assumes afe is driven from the converter's registers on hclk.
 */
`timescale 1ns/1ps

module adcc_analog_model #(
    parameter logic [8*adcc_pkg::RES_W-1:0] LEVELS = 64'h0  // Ch7..ch0
) (
    input  wire adcc_pkg::adcc_afe_t afe,
    output      logic                compare_above
);
    import adcc_pkg::*;

    logic [RES_W-1:0] level;               // Selected input level

    // One input at a time reaches the single engine
    assign level = LEVELS[afe.chan*RES_W +: RES_W];

    // Half-LSB above the code, so the search settles on the code itself
    assign compare_above = ({level, 1'b1} > {afe.dac, 1'b0});
endmodule : adcc_analog_model

// [testbench/tb.sv]
/*
 * Self-checking bench of the converter control block: AHB-Lite
 * master tasks, trigger pin stimulus and the analog model.
 * Assumes one slave, so hready is the block's own hreadyout.
 */
`timescale 1ns/1ps

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
    errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end end

module tb;
    import adcc_pkg::*;

    localparam logic [63:0] LEVELS = 64'hFF00C3_3C817E01A5; // Ch7..ch0
    localparam int          WAIT_MAX = 2000;   // Above one conversion

    logic                hclk;
    logic                hresetn;
    logic                hsel;
    logic [31:0]         haddr;
    logic [1:0]          htrans;
    logic                hwrite;
    logic [31:0]         hwdata;
    logic                hreadyout;
    logic                hresp;
    logic [31:0]         hrdata;
    logic                ext_trig;
    logic                compare_above;
    adcc_afe_t           afe;
    logic                conversion_done_irq;
    int                  errors;
    int                  n_checks;
    logic [31:0]         rd;
    int                  n;

    adcc_top adcc_top_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .external_trigger_input(ext_trig),
        .compare_above(compare_above), .afe(afe),
        .conversion_done_irq(conversion_done_irq)
    );

    adcc_analog_model #(.LEVELS(LEVELS)) adcc_analog_model_i (
        .afe(afe), .compare_above(compare_above)
    );

    // 200 MHz bus clock
    always #2.5 hclk = ~hclk;

    // Expected code of one input
    function automatic logic [7:0] lvl(input int ch);
        return LEVELS[ch*8 +: 8];
    endfunction : lvl

    // Mode word from its fields
    function automatic logic [31:0] mode(input logic run, scan, start,
                                         hw, input logic [2:0] ch);
        logic [31:0] m;
        m = 32'h0;
        m[MODE_RUN_BIT] = run;
        m[MODE_SCAN_BIT] = scan;
        m[MODE_START_BIT] = start;
        m[MODE_HWEN_BIT] = hw;
        m[MODE_CH_LSB +: CH_W] = ch;
        return m;
    endfunction : mode

    // One single AHB transfer; request held until hready seen high
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? wd : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(1'b1, a, d, dummy);
    endtask : wr

    // Bounded wait for the interrupt; count returned for timing
    task automatic wait_irq(output int cnt);
        cnt = 0;
        while (conversion_done_irq !== 1'b1 && cnt < WAIT_MAX) begin
            @(posedge hclk);
            cnt++;
        end
        `CHK(conversion_done_irq, 1'b1)
    endtask : wait_irq

    // Reset values and an unmapped place
    task automatic t_reset;
        logic [7:0] offs [5] = '{ADDR_MODE, ADDR_RESULT, ADDR_STATUS,
                                 ADDR_MASK, 8'h10};
        `CHK(conversion_done_irq, 1'b0)
        `CHK(afe, 12'h0)
        foreach (offs[i]) begin
            xfer(1'b0, offs[i], 32'h0, rd);
            `CHK(rd, 32'h0)
        end
        `CHK(hresp, 1'b0)
        $display("test reset done");
    endtask : t_reset

    // Software start in select mode, repeated on one channel
    task automatic t_select;
        wr(ADDR_MASK, 32'h1);
        wr(ADDR_MODE, mode(1, 0, 1, 0, 5));
        #1 `CHK({afe.sample, afe.chan}, 4'hD)
        wait_irq(n);
        `CHK(n inside {[1495:1505]}, 1'b1)
        xfer(1'b0, ADDR_RESULT, 32'h0, rd);
        `CHK(rd[7:0], lvl(5))
        xfer(1'b0, ADDR_STATUS, 32'h0, rd);
        `CHK({rd[STAT_CH_LSB +: CH_W], rd[STAT_BUSY_BIT]}, 4'hB)
        wr(ADDR_STATUS, 32'h1);
        @(posedge hclk);
        #1 `CHK(conversion_done_irq, 1'b0)
        wait_irq(n);
        xfer(1'b0, ADDR_RESULT, 32'h0, rd);
        `CHK(rd[7:0], lvl(5))
        wr(ADDR_MODE, 32'h0);
        wr(ADDR_STATUS, 32'h3);
        $display("test select done");
    endtask : t_select

    // Scan of channels 0..2 with wrap, result not writable
    task automatic t_scan;
        wr(ADDR_MODE, mode(1, 1, 1, 0, 2));
        for (int k = 0; k < 5; k++) begin
            wait_irq(n);
            xfer(1'b0, ADDR_RESULT, 32'h0, rd);
            `CHK(rd[7:0], lvl(k % 3))
            wr(ADDR_STATUS, 32'h1);
            @(posedge hclk);
        end
        wr(ADDR_RESULT, 32'h5A);
        xfer(1'b0, ADDR_RESULT, 32'h0, rd);
        `CHK(rd, {24'h0, lvl(1)})
        wr(ADDR_MODE, 32'h0);
        wr(ADDR_STATUS, 32'h3);
        $display("test scan done");
    endtask : t_scan

    // Stop written in mid-conversion leaves no result
    task automatic t_halt;
        wr(ADDR_MODE, mode(1, 0, 1, 0, 4));
        repeat (700) @(posedge hclk);
        wr(ADDR_MODE, 32'h0);
        xfer(1'b0, ADDR_STATUS, 32'h0, rd);
        `CHK(rd[STAT_BUSY_BIT], 1'b0)
        repeat (1600) @(posedge hclk);
        xfer(1'b0, ADDR_STATUS, 32'h0, rd);
        `CHK(rd[1:0], 2'h0)
        xfer(1'b0, ADDR_RESULT, 32'h0, rd);
        `CHK(rd[7:0], lvl(1))
        $display("test halt done");
    endtask : t_halt

    // Trigger pin start, edge not level, masked interrupt
    task automatic t_trig;
        wr(ADDR_MASK, 32'h0);
        wr(ADDR_MODE, mode(1, 0, 0, 1, 3));
        @(posedge hclk);
        ext_trig <= 1'b1;
        repeat (20) @(posedge hclk);
        xfer(1'b0, ADDR_STATUS, 32'h0, rd);
        `CHK({rd[STAT_BUSY_BIT], rd[STAT_TRIG_BIT]}, 2'h3)
        wr(ADDR_STATUS, 32'h2);
        xfer(1'b0, ADDR_STATUS, 32'h0, rd);
        `CHK(rd[STAT_TRIG_BIT], 1'b0)
        ext_trig <= 1'b0;
        repeat (1600) @(posedge hclk);
        xfer(1'b0, ADDR_STATUS, 32'h0, rd);
        `CHK({rd[1:0], conversion_done_irq}, 3'h2)
        xfer(1'b0, ADDR_RESULT, 32'h0, rd);
        `CHK(rd[7:0], lvl(3))
        wr(ADDR_MASK, 32'h3);
        @(posedge hclk);
        #1 `CHK(conversion_done_irq, 1'b1)
        wr(ADDR_MODE, 32'h0);
        $display("test trigger done");
    endtask : t_trig

    // Verdict and end of run
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    // Main sequence
    initial begin
        {hclk, hresetn, hsel, hwrite, ext_trig} = 5'h0;
        {haddr, hwdata, htrans} = 66'h0;
        errors = 0;
        n_checks = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_select();
        t_scan();
        t_halt();
        t_trig();
        finish_test();
    end

    // Watchdog, well past the expected run
    initial begin
        #400us;
        errors++;
        finish_test();
    end
endmodule : tb
